/* File: hdl/iofr_defs.svh */
`ifndef IOFR_DEFS_SVH
`define IOFR_DEFS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define IOFR_N_AI        8
`define IOFR_N_CH        4
`define IOFR_N_AO        4
`define IOFR_N_SIG       19
`define IOFR_N_DI        20
`define IOFR_N_DIN       8
`define IOFR_N_DO        7
`define IOFR_N_RELAY     3
`define IOFR_N_STAT      25
`define IOFR_N_FLT       15
`define IOFR_N_NODE      16

// ----------------------------------------
// Select codes and field values
// ----------------------------------------
`define IOFR_AI_SEL_DFLT 3'h0
`define IOFR_AI_SEL_BUS  3'h5
`define IOFR_DI_SEL_CONST 4'h0
`define IOFR_DI_SEL_BUS  4'h9
`define IOFR_SHARE_PEER  2'h1
`define IOFR_SHARE_LINE  2'h2
`define IOFR_SEV_MINOR   2'h1
`define IOFR_SEV_MAJOR   2'h2

// ----------------------------------------
// Loop current scaling, percent in 0.1 % units
// ----------------------------------------
`define IOFR_LOOP_MIN_MA 4
`define IOFR_LOOP_MAX_MA 20
`define IOFR_PCT_FULL    1000

// ----------------------------------------
// Reset values, highest element first
// ----------------------------------------
`define IOFR_AI_SEL_RST  {3'h0, 3'h0, 3'h3, 3'h0, 3'h2, 3'h1, 3'h4, 3'h0}
`define IOFR_AI_DFLT_RST {16'h03e8, 16'h0019, 16'h0019, 16'h03e8, \
                          16'h01f4, 16'h0064, 16'h0000, 16'h1414}
`define IOFR_AO_SEL_RST  {5'h03, 5'h06, 5'h05, 5'h04}
`define IOFR_AO_DFLT_RST 64'h0
`define IOFR_DI_SEL_RST  {4'h0, 4'h4, 4'h8, 4'h6, 4'h5, 4'h4, 4'h0, 4'h7, 4'h7, 4'h7, \
                          4'h8, 4'h8, 4'h0, 4'h3, 4'h2, 4'h3, 4'h2, 4'h1, 4'h1, 4'h0}
`define IOFR_DI_INV_RST  20'h01504
`define IOFR_DO_SEL_RST  {5'h0f, 5'h09, 5'h01, 5'h02, 5'h11, 5'h02, 5'h01}
`define IOFR_DO_OPEN_RST 7'h00
`define IOFR_SEV_RST     30'h15555555
`define IOFR_MODE_RST    2'h1
`define IOFR_NODE_RST    5'h01
`define IOFR_SEG_RST     32'h00000001
`define IOFR_LEAVE_RST   1'b0

`endif

/* File: hdl/iofr_pkg.sv */
`include "iofr_defs.svh"

package iofr_pkg;

   // ----------------------------------------
   // Whole configuration image
   // ----------------------------------------
   typedef struct packed {
      logic [`IOFR_N_AI-1:0][2:0]    ai_channel_select;
      logic [`IOFR_N_AI-1:0][15:0]   ai_default_value;
      logic [`IOFR_N_AO-1:0][4:0]    ao_source_select;
      logic [`IOFR_N_AO-1:0][15:0]   ao_default_value;
      logic [`IOFR_N_DI-1:0][3:0]    di_channel_select;
      logic [`IOFR_N_DI-1:0]         di_invert;
      logic [`IOFR_N_DO-1:0][4:0]    do_source_select;
      logic [`IOFR_N_DO-1:0]         do_open_for_action;
      logic [`IOFR_N_FLT-1:0][1:0]   fault_severity;
      logic [1:0]                    sharing_mode;
      logic [4:0]                    own_node_number;
      logic [`IOFR_N_NODE-1:0][1:0]  node_segment;
      logic                          leave_sharing_flag;
   } iofr_cfg_t;

endpackage

/* File: hdl/iofr_di_route.sv */
`include "iofr_defs.svh"

module iofr_di_route (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic [3:0]              channel_select,
   input  wire logic                    invert,
   input  wire logic [`IOFR_N_DIN-1:0]  din,
   input  wire logic                    bus_value,
   output logic                         func_r
);

   // ----------------------------------------
   // One discrete input function
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         func_r <= 1'b0;
      end else if (channel_select == `IOFR_DI_SEL_CONST) begin
         func_r <= invert;
      end else if (channel_select == `IOFR_DI_SEL_BUS) begin
         // Bus word already carries the meaning, no flip
         func_r <= bus_value;
      end else if (channel_select < `IOFR_DI_SEL_BUS) begin
         // Closed contact is 1; flip turns it to open-for-action
         func_r <= din[3'(channel_select - 4'h1)] ^ invert;
      end else begin
         func_r <= invert;
      end
   end

endmodule

/* File: hdl/iofr_out_sel.sv */
`include "iofr_defs.svh"

module iofr_out_sel (
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic [4:0]               source_select,
   input  wire logic                     open_for_action,
   input  wire logic [`IOFR_N_STAT-1:0]  status,
   output logic                          out_r
);

   // ----------------------------------------
   // One relay or indicator output
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         out_r <= 1'b0;
      end else if (source_select == 5'h00) begin
         out_r <= open_for_action;
      end else if (source_select <= 5'(`IOFR_N_STAT)) begin
         out_r <= status[source_select - 5'h01] ^ open_for_action;
      end else begin
         // Out-of-range code behaves as unassigned
         out_r <= open_for_action;
      end
   end

endmodule

/* File: hdl/iofr_top.sv */
`include "iofr_defs.svh"

// What this block does
// - Analog function select zero gives its default value and never a failure.
// - Analog select five takes the bus word; failure follows bus communication.
// - Analog selects one to four route that physical analog channel.
// - Analog output with select zero drives its default value.
// - Nonzero analog output select n, up to 19, routes signal list entry n.
// - Output percent maps linearly, zero percent 4 mA, full 20 mA.
// - Discrete selects one to eight route that physical discrete input.
// - Discrete select zero drives the function with its flip setting.
// - Discrete select nine takes the function value from its bus bit.
// - Discrete function acts on closed contact; flip makes it open contact.
// - Relay and indicator outputs follow status list entry n, up to 25.
// - Relay or indicator select zero drives its open-for-action flag.
// - Status code three is minor or major alarm.
// - Status code four is any input or output in test.
// - Status code 23 is failed communication with any configured peer.
// - Two-bit severity per fault: none, minor, major.
// - Sharing mode one picks peer network, two picks analog share line.
// - Own node number identifies this unit among sixteen nodes.
// - Node segment zero marks a node unused, no fault expected.
// - Configuration error when own node segment entry is zero.
// - Leave flag is passed to peers so they ignore this unit.

module iofr_top (
   input  wire logic                              clk,
   input  wire logic                              nrst,
   input  wire logic                              cfg_load,
   input  wire iofr_pkg::iofr_cfg_t               cfg_in,
   input  wire logic [`IOFR_N_CH-1:0][15:0]       ai_chan_in,
   input  wire logic [`IOFR_N_CH-1:0]             ai_hw_fault,
   input  wire logic [`IOFR_N_AI-1:0][15:0]       ai_bus_value,
   input  wire logic                              bus_comm_fail,
   input  wire logic [`IOFR_N_SIG-1:0][15:0]      ao_signal,
   input  wire logic [`IOFR_N_DIN-1:0]            din,
   input  wire logic [`IOFR_N_DI-1:0]             di_bus_value,
   input  wire logic [3:0]                        io_test,
   input  wire logic [1:0]                        spd_fault,
   input  wire logic                              spd_diff_fault,
   input  wire logic [13:0]                       plant_status,
   input  wire logic [`IOFR_N_NODE-1:0]           node_comm_fail,
   output logic [`IOFR_N_AI-1:0][15:0]            ai_value_r,
   output logic [`IOFR_N_AI-1:0]                  ai_fault_r,
   output logic [`IOFR_N_AO-1:0][15:0]            ao_current_ua_r,
   output logic [`IOFR_N_DI-1:0]                  di_func_r,
   output logic [`IOFR_N_RELAY-1:0]               relay_out_r,
   output logic [`IOFR_N_DO-`IOFR_N_RELAY-1:0]    indicator_r,
   output logic [`IOFR_N_STAT-1:0]                status_r,
   output logic                                   minor_alarm_r,
   output logic                                   major_alarm_r,
   output logic                                   peer_comm_fail_r,
   output logic                                   cfg_error_r,
   output logic                                   peer_net_sel_r,
   output logic                                   analog_share_line_r,
   output logic [4:0]                             own_node_number_r,
   output logic                                   leave_sharing_flag_r
);

   // ----------------------------------------
   // Scaling constants
   // ----------------------------------------
   localparam int ZERO_UA  = `IOFR_LOOP_MIN_MA * 1000;
   localparam int SLOPE_UA = (`IOFR_LOOP_MAX_MA - `IOFR_LOOP_MIN_MA) * 1000 / `IOFR_PCT_FULL;
   localparam int MAX_UA   = 65535;

   iofr_pkg::iofr_cfg_t               cfg_r;
   logic [`IOFR_N_AI-1:0][15:0]       ai_val_nxt;
   logic [`IOFR_N_AI-1:0]             ai_flt_nxt;
   logic [`IOFR_N_AO-1:0][15:0]       ao_cur_nxt;
   logic [`IOFR_N_FLT-1:0]            fault_vec;
   logic                              minor_nxt;
   logic                              major_nxt;
   logic                              peer_fail_nxt;
   logic                              cfg_error_nxt;
   logic [3:0]                        own_idx;
   logic [`IOFR_N_STAT-1:0]           status_nxt;
   logic [`IOFR_N_DO-1:0]             do_out;

   // ----------------------------------------
   // Configuration store
   // ----------------------------------------
   // Whole image loads at once so related selects never mix
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cfg_r.ai_channel_select  <= `IOFR_AI_SEL_RST;
         cfg_r.ai_default_value   <= `IOFR_AI_DFLT_RST;
         cfg_r.ao_source_select   <= `IOFR_AO_SEL_RST;
         cfg_r.ao_default_value   <= `IOFR_AO_DFLT_RST;
         cfg_r.di_channel_select  <= `IOFR_DI_SEL_RST;
         cfg_r.di_invert          <= `IOFR_DI_INV_RST;
         cfg_r.do_source_select   <= `IOFR_DO_SEL_RST;
         cfg_r.do_open_for_action <= `IOFR_DO_OPEN_RST;
         cfg_r.fault_severity     <= `IOFR_SEV_RST;
         cfg_r.sharing_mode       <= `IOFR_MODE_RST;
         cfg_r.own_node_number    <= `IOFR_NODE_RST;
         cfg_r.node_segment       <= `IOFR_SEG_RST;
         cfg_r.leave_sharing_flag <= `IOFR_LEAVE_RST;
      end else if (cfg_load) begin
         cfg_r <= cfg_in;
      end
   end

   // ----------------------------------------
   // Analog input functions
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < `IOFR_N_AI; i++) begin
         ai_val_nxt[i] = cfg_r.ai_default_value[i];
         ai_flt_nxt[i] = 1'b0;
         if (cfg_r.ai_channel_select[i] == `IOFR_AI_SEL_BUS) begin
            ai_val_nxt[i] = ai_bus_value[i];
            ai_flt_nxt[i] = bus_comm_fail;
         end else if (cfg_r.ai_channel_select[i] != `IOFR_AI_SEL_DFLT &&
                      cfg_r.ai_channel_select[i] < `IOFR_AI_SEL_BUS) begin
            ai_val_nxt[i] = ai_chan_in[2'(cfg_r.ai_channel_select[i] - 3'h1)];
            ai_flt_nxt[i] = ai_hw_fault[2'(cfg_r.ai_channel_select[i] - 3'h1)];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ai_value_r <= '0;
         ai_fault_r <= '0;
      end else begin
         ai_value_r <= ai_val_nxt;
         ai_fault_r <= ai_flt_nxt;
      end
   end

   // ----------------------------------------
   // Analog outputs
   // ----------------------------------------
   // Select 19 lies past the tunable range yet still routes the last entry
   always_comb begin
      int pct;
      int cur;
      pct = 0;
      cur = 0;
      for (int j = 0; j < `IOFR_N_AO; j++) begin
         pct = int'($signed(cfg_r.ao_default_value[j]));
         if (cfg_r.ao_source_select[j] != 5'h00 &&
             cfg_r.ao_source_select[j] <= 5'(`IOFR_N_SIG)) begin
            pct = int'($signed(ao_signal[cfg_r.ao_source_select[j] - 5'h01]));
         end
         cur = ZERO_UA + SLOPE_UA * pct;
         // Loop driver cannot sink, clamp below zero
         if (cur < 0) begin
            cur = 0;
         end else if (cur > MAX_UA) begin
            cur = MAX_UA;
         end
         ao_cur_nxt[j] = 16'(cur);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ao_current_ua_r <= '0;
      end else begin
         ao_current_ua_r <= ao_cur_nxt;
      end
   end

   // ----------------------------------------
   // Discrete input functions
   // ----------------------------------------
   for (genvar k = 0; k < `IOFR_N_DI; k++) begin : g_di
      iofr_di_route u_di (
         .clk            (clk),
         .nrst           (nrst),
         .channel_select (cfg_r.di_channel_select[k]),
         .invert         (cfg_r.di_invert[k]),
         .din            (din),
         .bus_value      (di_bus_value[k]),
         .func_r         (di_func_r[k])
      );
   end

   // ----------------------------------------
   // Alarm summaries
   // ----------------------------------------
   assign fault_vec = {bus_comm_fail, ai_flt_nxt[6:0], spd_diff_fault, spd_fault, io_test};

   always_comb begin
      minor_nxt = 1'b0;
      major_nxt = 1'b0;
      for (int f = 0; f < `IOFR_N_FLT; f++) begin
         // Code three is reserved and raises nothing
         if (fault_vec[f] && cfg_r.fault_severity[f] == `IOFR_SEV_MINOR) begin
            minor_nxt = 1'b1;
         end
         if (fault_vec[f] && cfg_r.fault_severity[f] == `IOFR_SEV_MAJOR) begin
            major_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         minor_alarm_r <= 1'b0;
         major_alarm_r <= 1'b0;
      end else begin
         minor_alarm_r <= minor_nxt;
         major_alarm_r <= major_nxt;
      end
   end

   // ----------------------------------------
   // Peer network supervision
   // ----------------------------------------
   assign own_idx = 4'(cfg_r.own_node_number - 5'h01);

   always_comb begin
      peer_fail_nxt = 1'b0;
      for (int n = 0; n < `IOFR_N_NODE; n++) begin
         if (cfg_r.node_segment[n] != 2'h0 && 4'(n) != own_idx &&
             node_comm_fail[n]) begin
            peer_fail_nxt = 1'b1;
         end
      end
   end

   // Node number zero has no segment entry and counts as an error
   assign cfg_error_nxt = (cfg_r.own_node_number == 5'h00) ||
                          (cfg_r.node_segment[own_idx] == 2'h0);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         peer_comm_fail_r     <= 1'b0;
         cfg_error_r          <= 1'b0;
         peer_net_sel_r       <= 1'b0;
         analog_share_line_r  <= 1'b0;
         own_node_number_r    <= 5'h00;
         leave_sharing_flag_r <= 1'b0;
      end else begin
         peer_comm_fail_r     <= peer_fail_nxt;
         cfg_error_r          <= cfg_error_nxt;
         peer_net_sel_r       <= cfg_r.sharing_mode == `IOFR_SHARE_PEER;
         analog_share_line_r  <= cfg_r.sharing_mode == `IOFR_SHARE_LINE;
         own_node_number_r    <= cfg_r.own_node_number;
         leave_sharing_flag_r <= cfg_r.leave_sharing_flag;
      end
   end

   // ----------------------------------------
   // Status signal list, bit k is code k+1
   // ----------------------------------------
   always_comb begin
      status_nxt        = '0;
      status_nxt[0]     = minor_nxt;
      status_nxt[1]     = major_nxt;
      status_nxt[2]     = minor_nxt | major_nxt;
      status_nxt[3]     = |io_test;
      status_nxt[7:4]   = ai_hw_fault;
      status_nxt[21:8]  = plant_status;
      status_nxt[22]    = peer_fail_nxt;
      status_nxt[24:23] = spd_fault;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         status_r <= '0;
      end else begin
         status_r <= status_nxt;
      end
   end

   // ----------------------------------------
   // Relay and indicator outputs
   // ----------------------------------------
   // Selection uses the same-cycle list so outputs align with status_r
   for (genvar d = 0; d < `IOFR_N_DO; d++) begin : g_do
      iofr_out_sel u_do (
         .clk             (clk),
         .nrst            (nrst),
         .source_select   (cfg_r.do_source_select[d]),
         .open_for_action (cfg_r.do_open_for_action[d]),
         .status          (status_nxt),
         .out_r           (do_out[d])
      );
   end

   assign relay_out_r = do_out[`IOFR_N_RELAY-1:0];
   assign indicator_r = do_out[`IOFR_N_DO-1:`IOFR_N_RELAY];

endmodule

/* File: tb/iofr_chk.sv */
`include "iofr_defs.svh"

module iofr_chk (
   input wire logic                      clk,
   input wire logic                      nrst,
   input wire logic                      cfg_load,
   input wire iofr_pkg::iofr_cfg_t       cfg_in,
   input wire logic [3:0]                io_test,
   input wire logic [`IOFR_N_AI-1:0]     ai_fault_r,
   input wire logic [`IOFR_N_DI-1:0]     di_func_r,
   input wire logic [`IOFR_N_STAT-1:0]   status_r,
   input wire logic                      minor_alarm_r,
   input wire logic                      major_alarm_r,
   input wire logic                      peer_comm_fail_r,
   input wire logic                      cfg_error_r,
   input wire logic                      peer_net_sel_r,
   input wire logic                      analog_share_line_r,
   input wire logic [4:0]                own_node_number_r,
   input wire logic                      leave_sharing_flag_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Shadow of the loaded image
   // ----------------------------------------
   iofr_pkg::iofr_cfg_t cfg_q;
   logic [1:0]          quiet_r;
   logic [1:0]          up_r;
   logic                loaded_r;
   logic                calm;

   // Only judged after an explicit load, so no copy of the reset image is needed
   assign calm = loaded_r && quiet_r == 2'h3;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         quiet_r <= 2'h0;
         up_r <= 2'h0;
         loaded_r <= 1'b0;
      end else begin
         up_r <= (up_r == 2'h3) ? 2'h3 : up_r + 2'h1;
         if (cfg_load) begin
            cfg_q <= cfg_in;
            quiet_r <= 2'h0;
            loaded_r <= 1'b1;
         end else if (quiet_r != 2'h3) begin
            quiet_r <= quiet_r + 2'h1;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_ai_zero; calm && cfg_q.ai_channel_select[0] == 3'h0 |-> !ai_fault_r[0]; endproperty
   a_ai_zero: assert property (p_ai_zero) else $error("analog fault with select zero");
   property p_di_const; calm && cfg_q.di_channel_select[0] == 4'h0 |->
      di_func_r[0] == cfg_q.di_invert[0]; endproperty
   a_di_const: assert property (p_di_const) else $error("discrete constant wrong");
   property p_either; status_r[2] == (minor_alarm_r | major_alarm_r); endproperty
   a_either: assert property (p_either) else $error("either alarm code wrong");
   property p_sev; status_r[1:0] == {major_alarm_r, minor_alarm_r}; endproperty
   a_sev: assert property (p_sev) else $error("alarm codes differ from summaries");
   property p_test; up_r == 2'h3 && io_test == $past(io_test) && io_test == $past(io_test, 2)
      |-> status_r[3] == |io_test; endproperty
   a_test: assert property (p_test) else $error("test code wrong");
   property p_peer; status_r[22] == peer_comm_fail_r; endproperty
   a_peer: assert property (p_peer) else $error("peer code wrong");
   property p_mode; calm |-> peer_net_sel_r == (cfg_q.sharing_mode == 2'h1)
      && analog_share_line_r == (cfg_q.sharing_mode == 2'h2); endproperty
   a_mode: assert property (p_mode) else $error("sharing mode outputs wrong");
   property p_node; cfg_load |-> ##2 own_node_number_r == $past(cfg_in.own_node_number, 2);
   endproperty
   a_node: assert property (p_node) else $error("node number not taken");
   property p_err; calm |-> cfg_error_r == (cfg_q.own_node_number == 5'h0
      || cfg_q.node_segment[cfg_q.own_node_number - 5'h1] == 2'h0); endproperty
   a_err: assert property (p_err) else $error("configuration error wrong");
   property p_leave; calm |-> leave_sharing_flag_r == cfg_q.leave_sharing_flag; endproperty
   a_leave: assert property (p_leave) else $error("leave flag wrong");
endmodule

bind iofr_top iofr_chk u_iofr_chk (.clk, .nrst, .cfg_load, .cfg_in, .io_test, .ai_fault_r,
   .di_func_r, .status_r, .minor_alarm_r, .major_alarm_r, .peer_comm_fail_r, .cfg_error_r,
   .peer_net_sel_r, .analog_share_line_r, .own_node_number_r, .leave_sharing_flag_r);

/* File: tb/iofr_field.sv */
`include "iofr_defs.svh"

// Field side: contacts and transmitters; a broken wire reads zero and is flagged
module iofr_field (
   input  wire logic [`IOFR_N_DIN-1:0]       contact,
   input  wire logic [`IOFR_N_CH-1:0][15:0]  level,
   input  wire logic [`IOFR_N_CH-1:0]        brk,
   output logic [`IOFR_N_DIN-1:0]            din,
   output logic [`IOFR_N_CH-1:0][15:0]       ai_chan_in,
   output logic [`IOFR_N_CH-1:0]             ai_hw_fault
);
   timeunit 1ns;
   timeprecision 1ps;

   assign din = contact;
   assign ai_hw_fault = brk;
   always_comb begin
      for (int i = 0; i < `IOFR_N_CH; i++) begin
         ai_chan_in[i] = brk[i] ? 16'h0000 : level[i];
      end
   end
endmodule

/* File: tb/io_function_router_test.sv */
`include "iofr_defs.svh"

module io_function_router_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                            clk = 1'b0;
   logic                            nrst = 1'b0;
   logic                            cfg_load = 1'b0;
   iofr_pkg::iofr_cfg_t             cfg = '0;
   logic [`IOFR_N_CH-1:0][15:0]     level = '0;
   logic [`IOFR_N_CH-1:0]           brk = '0;
   logic [`IOFR_N_DIN-1:0]          contact = '0;
   logic [`IOFR_N_AI-1:0][15:0]     ai_bus = '0;
   logic                            bus_fail = 1'b0;
   logic [`IOFR_N_SIG-1:0][15:0]    sig = '0;
   logic [`IOFR_N_DI-1:0]           di_bus = '0;
   logic [3:0]                      io_test = '0;
   logic [1:0]                      spd_fault = '0;
   logic [`IOFR_N_NODE-1:0]         node_fail = '0;
   logic [`IOFR_N_DIN-1:0]          din;
   logic [`IOFR_N_CH-1:0][15:0]     chan;
   logic [`IOFR_N_CH-1:0]           hw_fault;
   logic [`IOFR_N_AI-1:0][15:0]     ai_value_r;
   logic [`IOFR_N_AI-1:0]           ai_fault_r;
   logic [`IOFR_N_AO-1:0][15:0]     ao_current_ua_r;
   logic [`IOFR_N_DI-1:0]           di_func_r;
   logic [`IOFR_N_RELAY-1:0]        relay_out_r;
   logic [`IOFR_N_DO-`IOFR_N_RELAY-1:0] indicator_r;
   logic                            peer_comm_fail_r;
   logic                            cfg_error_r;
   logic                            peer_net_sel_r;
   logic                            analog_share_line_r;
   logic [4:0]                      own_node_number_r;
   logic                            leave_sharing_flag_r;
   int                              err_count = 0;
   int                              checks = 0;

   iofr_field u_iofr_field (.contact(contact), .level(level), .brk(brk), .din(din),
      .ai_chan_in(chan), .ai_hw_fault(hw_fault));

   iofr_top u_iofr_top (.clk(clk), .nrst(nrst), .cfg_load(cfg_load), .cfg_in(cfg),
      .ai_chan_in(chan), .ai_hw_fault(hw_fault), .ai_bus_value(ai_bus),
      .bus_comm_fail(bus_fail), .ao_signal(sig), .din(din), .di_bus_value(di_bus),
      .io_test(io_test), .spd_fault(spd_fault), .spd_diff_fault(1'b0),
      .plant_status(14'(contact)), .node_comm_fail(node_fail), .ai_value_r(ai_value_r),
      .ai_fault_r(ai_fault_r), .ao_current_ua_r(ao_current_ua_r), .di_func_r(di_func_r),
      .relay_out_r(relay_out_r), .indicator_r(indicator_r), .status_r(),
      .minor_alarm_r(), .major_alarm_r(), .peer_comm_fail_r(peer_comm_fail_r),
      .cfg_error_r(cfg_error_r), .peer_net_sel_r(peer_net_sel_r),
      .analog_share_line_r(analog_share_line_r), .own_node_number_r(own_node_number_r),
      .leave_sharing_flag_r(leave_sharing_flag_r));

   always #25 clk = ~clk;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task cmp16(string name, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task cmp1(string name, logic exp, logic got);
      cmp16(name, {15'h0000, exp}, {15'h0000, got});
   endtask
   // Inputs always move 1 ns after the edge, outputs are read there too
   task tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task load;
      cfg_load = 1'b1;
      tick(1);
      cfg_load = 1'b0;
      tick(4);
   endtask
   task test_done;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      cmp16("own node", 16'(`IOFR_NODE_RST), 16'(own_node_number_r));
      cmp1("peer net", 1'b1, peer_net_sel_r);
      cmp1("cfg error", 1'b0, cfg_error_r);
      cmp1("leave", 1'b0, leave_sharing_flag_r);
   endtask
   task t_ai;
      logic [15:0] v;
      logic        f;
      for (int i = 0; i < 8; i++) begin
         cfg.ai_channel_select[i] = 3'(i);
         cfg.ai_default_value[i] = 16'h0100 + 16'(i);
         ai_bus[i] = 16'h2000 + 16'(i);
      end
      level = {16'h1003, 16'h1002, 16'h1001, 16'h1000};
      brk = 4'h4;
      bus_fail = 1'b1;
      load;
      for (int i = 0; i < 8; i++) begin
         if (i >= 1 && i <= 4) begin
            v = brk[i-1] ? 16'h0000 : 16'h1000 + 16'(i - 1);
            f = brk[i-1];
         end else if (i == 5) begin
            v = 16'h2005;
            f = 1'b1;
         end else begin
            v = 16'h0100 + 16'(i);
            f = 1'b0;
         end
         cmp16("ai value", v, ai_value_r[i]);
         cmp1("ai fault", f, ai_fault_r[i]);
      end
      bus_fail = 1'b0;
      tick(3);
      cmp1("ai bus fault", 1'b0, ai_fault_r[5]);
   endtask
   task t_ao;
      cfg.ao_source_select = {5'h12, 5'h13, 5'h01, 5'h00};
      cfg.ao_default_value[0] = 16'h03e8;
      sig[0] = 16'hff38;
      sig[17] = 16'h00fa;
      sig[18] = 16'h01f4;
      load;
      cmp16("ao dflt", 16'h4e20, ao_current_ua_r[0]);
      cmp16("ao sel1", 16'h0320, ao_current_ua_r[1]);
      cmp16("ao sel19", 16'h2ee0, ao_current_ua_r[2]);
      cmp16("ao sel18", 16'h1f40, ao_current_ua_r[3]);
   endtask
   task t_di;
      logic b;
      cfg.di_channel_select[5:0] = {4'hc, 4'h8, 4'h9, 4'h3, 4'h3, 4'h0};
      cfg.di_invert[5:0] = 6'h2d;
      load;
      for (int k = 0; k < 2; k++) begin
         b = k[0];
         contact = b ? 8'h84 : 8'h00;
         di_bus[3] = b;
         tick(2);
         cmp1("di const", 1'b1, di_func_r[0]);
         cmp1("di closed", b, di_func_r[1]);
         cmp1("di open", !b, di_func_r[2]);
         cmp1("di bus", b, di_func_r[3]);
         cmp1("di ch8", b, di_func_r[4]);
         cmp1("di illegal", 1'b1, di_func_r[5]);
      end
   endtask

   task t_out;
      cfg.fault_severity = '0;
      cfg.fault_severity[0] = 2'h1;
      cfg.fault_severity[4] = 2'h2;
      cfg.fault_severity[5] = 2'h3;
      cfg.do_source_select = {5'h19, 5'h02, 5'h01, 5'h17, 5'h04, 5'h03, 5'h00};
      cfg.do_open_for_action = 7'h05;
      load;
      io_test = 4'h1;
      tick(4);
      cmp16("outs test", 16'h0013, 16'({indicator_r, relay_out_r}));
      io_test = 4'h0;
      spd_fault = 2'h1;
      tick(4);
      cmp16("outs major", 16'h0027, 16'({indicator_r, relay_out_r}));
      spd_fault = 2'h2;
      tick(4);
      cmp16("outs none", 16'h0045, 16'({indicator_r, relay_out_r}));
   endtask

   task t_peer;
      cfg.own_node_number = 5'h03;
      cfg.node_segment = '0;
      cfg.node_segment[0] = 2'h1;
      cfg.node_segment[2] = 2'h2;
      cfg.sharing_mode = 2'h2;
      cfg.leave_sharing_flag = 1'b1;
      load;
      node_fail = 16'h0006;
      tick(4);
      cmp1("peer unused", 1'b0, peer_comm_fail_r);
      cmp1("cfg error", 1'b0, cfg_error_r);
      cmp1("share line", 1'b1, analog_share_line_r);
      cmp1("peer net", 1'b0, peer_net_sel_r);
      cmp1("leave", 1'b1, leave_sharing_flag_r);
      node_fail = 16'h0001;
      tick(4);
      cmp1("peer fail", 1'b1, peer_comm_fail_r);
      cmp1("ind peer", 1'b1, indicator_r[0]);
      cfg.node_segment[2] = 2'h0;
      cfg.do_source_select[4] = 5'h10;
      load;
      cmp1("cfg error", 1'b1, cfg_error_r);
      cmp1("ind plant", 1'b1, indicator_r[1]);
   endtask

   initial begin
      tick(16);
      nrst = 1'b1;
      tick(2);
      t_reset;
      t_ai;
      t_ao;
      t_di;
      t_out;
      t_peer;
      test_done;
   end

   // Whole run is some 75 cycles
   initial begin
      tick(3000);
      err_count++;
      test_done;
   end
endmodule
